// *** inc/rx_ctrl_pkg.sv ***
package rx_ctrl_pkg;

    // Serial bus
    localparam logic [6:0] DEV_ADDR        = 7'h48;
    localparam logic [7:0] NUM_CTRL_REGS   = 8'h08;

    // Register offsets
    localparam logic [7:0] RECTIFIER_CONFIG_OFS       = 8'h00;
    localparam logic [7:0] CHARGE_CONFIG_OFS          = 8'h01;
    localparam logic [7:0] PRECHARGE_LEVEL_OFS        = 8'h02;
    localparam logic [7:0] ANALOG_SELECT_OFS          = 8'h03;
    localparam logic [7:0] CURRENT_LIMIT_SET_OFS      = 8'h04;
    localparam logic [7:0] THERMISTOR_MISC_OFS        = 8'h05;
    localparam logic [7:0] SENSE_GAIN_OFS             = 8'h06;
    localparam logic [7:0] SPARE_CONTROL_OFS          = 8'h07;
    localparam logic [7:0] FAULT_STATUS_OFS           = 8'h08;
    localparam logic [7:0] CTRL_RESET                 = 8'h00;

    // rectifier_config bits
    localparam int LOW_SIDE_FORCE_BIT   = 7;
    localparam int DETECT_CFG_BIT       = 6;
    localparam int HALF_SYNC_BIT        = 5;
    localparam int CONTROL_A_BIT        = 4;
    localparam int REF_ENABLE_BIT       = 3;
    localparam int REGULATE_BIT         = 2;
    localparam int PRECHARGE_EN_BIT     = 1;
    localparam int SWITCH_ENABLE_BIT    = 0;

    // charge_config bits
    localparam int INDIRECT_SEL_BIT     = 3;
    localparam int PACK_LOAD_BIT        = 2;
    localparam int OV_FORCE_BIT         = 1;
    localparam int MOD_ENABLE_BIT       = 0;

    // analog_select bits
    localparam int DIV_RATIO_BIT        = 3;
    localparam int ASEL_LSB             = 0;

    // thermistor_misc_control bits
    localparam int HIGH_RES_BIT         = 7;
    localparam int CORE_TUNE_BIT        = 5;
    localparam int PULLDOWN_BIT         = 4;
    localparam int OV_FET_MODE_BIT      = 3;
    localparam int REF_KILL_BIT         = 2;
    localparam int THERMISTOR_PIN_LSB            = 0;

    // sense_gain fields
    localparam int BATT_GAIN_LSB        = 3;
    localparam int OUT_GAIN_LSB         = 0;

    // Thermistor driver codes
    localparam logic [1:0] THERMISTOR_PIN_OFF    = 2'h0;
    localparam logic [1:0] THERMISTOR_PIN_ON     = 2'h1;
    localparam logic [1:0] THERMISTOR_PIN_AUTO   = 2'h2;

    localparam logic [2:0] ASEL_NONE    = 3'h0;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_OFFSET,
        ST_ACK_OFS,
        ST_WRITE,
        ST_ACK_WR,
        ST_READ,
        ST_RACK
    } bus_state_e;

endpackage

// *** rtl/rx_ctrl_regs.sv ***
`timescale 1ns/10ps
// Summary of operation
// [R1] Low-side force turns both low FETs on
// [R2] Detect cfg bit: totem-pole high, open-drain low
// [R3] Half-sync low: only low-side FETs switch
// [R4] Control_a low disables sync, overrides half-sync
// [R5] Reference enable bit powers precision reference
// [R6] Reference kill forces reference off
// [R7] Load switch mode: off, regulator, plain switch
// [R8] Precharge enable bit gates precharge source
// [R9] Indirect charge select bit at offset 1
// [R10] Pack load bit connects 500 Ohm load
// [R11] Over-voltage force or rectified OV turns FET
// [R12] FET mode: current source high, switch low
// [R13] Modulation enable drives modulation FETs
// [R14] Three-bit precharge level at offset 2
// [R15] Three-bit analog select plus divider ratio
// [R16] Select code zero leaves mux pin floating
// [R17] Four-bit indirect current limit at offset 4
// [R18] Two-bit thermistor control at offset 5
// [R19] Thermistor: off, on, auto with charging
// [R20] Pulldown bit loads mux buffer output
// [R21] Core regulator tuning bit for indirect
// [R22] High-resistance bit raises high-side on-resistance
// [R23] Two three-bit sense gain fields at 6
// [R24] Seven-bit output voltage setpoint field
// [R25] Setpoint code passed unchanged to regulator
// [R26] Fault register reports both over-voltage levels
// [R27] Fault register reports over-temperature level
// [R28] Fault register reports USB presence level
// [R29] Fault register reports current-limit level
// [R30] Answers serial bus address 0x48 only
// [R31] Offset byte, then data; fault register read-only
module rx_ctrl_regs
    import rx_ctrl_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       ce_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic       power_present_i,
    input  wire logic       pack_ov_i,
    input  wire logic       rect_ov_i,
    input  wire logic       over_temp_i,
    input  wire logic       usb_present_i,
    input  wire logic       current_limit_i,
    output logic            power_detect_o,
    output logic            power_detect_oe_o,
    output logic            low_side_force_o,
    output logic            rect_control_a_o,
    output logic            rect_half_sync_o,
    output logic            rect_full_sync_o,
    output logic            reference_enable_o,
    output logic            ls_regulator_o,
    output logic            ls_switch_o,
    output logic            precharge_enable_o,
    output logic [2:0]      precharge_level_o,
    output logic            indirect_charge_select_o,
    output logic            pack_load_enable_o,
    output logic            overvoltage_fet_on_o,
    output logic            overvoltage_fet_mode_o,
    output logic            modulation_enable_o,
    output logic [2:0]      analog_select_field_o,
    output logic            analog_mux_enable_o,
    output logic            rectified_divider_ratio_o,
    output logic [3:0]      indirect_current_limit_o,
    output logic            thermistor_drive_o,
    output logic            mux_pulldown_enable_o,
    output logic            core_regulator_tuning_o,
    output logic            high_resistance_select_o,
    output logic [2:0]      battery_sense_gain_o,
    output logic [2:0]      output_sense_gain_o,
    output logic [6:0]      output_voltage_setpoint_o
);

    typedef struct packed {
        logic [1:0]       scl_s;
        logic [1:0]       sda_s;
        logic             scl_d;
        logic             sda_d;
        logic [1:0][5:0]  flag_s;
        bus_state_e       st;
        logic [3:0]       bitcnt;
        logic [7:0]       shreg;
        logic [7:0]       ptr;
        logic             rw;
        logic             nack;
        logic             sda_oe;
        logic             det_pin;
        logic             det_oe;
        logic             rect_control_a;
        logic             rect_half;
        logic             rect_full;
        logic             ref_en;
        logic             sw_on;
        logic             ovfet_on;
        logic             mux_en;
        logic             thermistor_pin_on;
        logic [7:0][7:0]  regs;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic       scl;
    logic       sda;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic [5:0] flags;
    logic [7:0] fault_byte;
    logic [7:0] rd_byte;
    logic [7:0] r0;
    logic [7:0] r1;
    logic [7:0] r5;
    logic [7:0] rd_ptr;
    logic [7:0] nr0;
    logic [7:0] nr1;
    logic [7:0] nr5;
    logic [5:0] nflg;

    assign scl       = st_r.scl_s[1];
    assign sda       = st_r.sda_s[1];
    assign scl_rise  = scl & ~st_r.scl_d;
    assign scl_fall  = ~scl & st_r.scl_d;
    // Data moving while the clock is high frames a transfer
    assign start_det = scl & st_r.scl_d & ~sda & st_r.sda_d;
    assign stop_det  = scl & st_r.scl_d & sda & ~st_r.sda_d;
    assign flags     = st_r.flag_s[1];

    // Live levels, no latching: each bit follows its condition
    assign fault_byte = {3'h0, flags[4:0]}; // [R26] [R27] [R28] [R29]

    // After a master ack the next byte must be loaded at that same clock fall
    assign rd_ptr = (st_r.st == ST_RACK) ? st_r.ptr + 8'h01 : st_r.ptr;

    always_comb begin
        if (rd_ptr < NUM_CTRL_REGS) begin
            rd_byte = st_r.regs[rd_ptr[2:0]]; // [R31]
        end else if (rd_ptr == FAULT_STATUS_OFS) begin
            rd_byte = fault_byte;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        st_nxt          = st_r;
        st_nxt.scl_s    = {st_r.scl_s[0], scl_i};
        st_nxt.sda_s    = {st_r.sda_s[0], sda_i};
        st_nxt.scl_d    = scl;
        st_nxt.sda_d    = sda;
        st_nxt.flag_s   = {st_r.flag_s[0],
                           {power_present_i, pack_ov_i, rect_ov_i,
                            over_temp_i, usb_present_i, current_limit_i}};
        if (start_det) begin
            st_nxt.st     = ST_ADDR;
            st_nxt.bitcnt = 4'h0;
            st_nxt.sda_oe = 1'b0;
        end else if (stop_det) begin
            st_nxt.st     = ST_IDLE;
            st_nxt.sda_oe = 1'b0;
        end else if (scl_rise) begin
            unique case (st_r.st)
                ST_ADDR, ST_OFFSET, ST_WRITE: begin
                    st_nxt.shreg  = {st_r.shreg[6:0], sda};
                    st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                end
                ST_READ: begin
                    st_nxt.bitcnt = st_r.bitcnt + 4'h1;
                end
                ST_RACK: begin
                    st_nxt.nack = sda;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (st_r.st)
                ST_ADDR: begin
                    if (st_r.bitcnt == 4'h8) begin
                        if (st_r.shreg[7:1] == DEV_ADDR) begin // [R30]
                            st_nxt.rw     = st_r.shreg[0];
                            st_nxt.sda_oe = 1'b1;
                            st_nxt.st     = ST_ACK_ADDR;
                        end else begin
                            st_nxt.st     = ST_IDLE;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    st_nxt.bitcnt = 4'h0;
                    if (st_r.rw) begin
                        st_nxt.shreg  = rd_byte;
                        st_nxt.sda_oe = ~rd_byte[7];
                        st_nxt.st     = ST_READ;
                    end else begin
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.st     = ST_OFFSET;
                    end
                end
                ST_OFFSET: begin
                    if (st_r.bitcnt == 4'h8) begin
                        st_nxt.ptr    = st_r.shreg; // [R31]
                        st_nxt.sda_oe = 1'b1;
                        st_nxt.st     = ST_ACK_OFS;
                    end
                end
                ST_ACK_OFS, ST_ACK_WR: begin
                    st_nxt.sda_oe = 1'b0;
                    st_nxt.bitcnt = 4'h0;
                    st_nxt.st     = ST_WRITE;
                end
                ST_WRITE: begin
                    if (st_r.bitcnt == 4'h8) begin
                        // Fault and unmapped offsets are acked but not stored
                        if (st_r.ptr < NUM_CTRL_REGS) begin
                            st_nxt.regs[st_r.ptr[2:0]] = st_r.shreg; // [R31]
                        end
                        st_nxt.ptr    = st_r.ptr + 8'h01;
                        st_nxt.sda_oe = 1'b1;
                        st_nxt.st     = ST_ACK_WR;
                    end
                end
                ST_READ: begin
                    if (st_r.bitcnt == 4'h8) begin
                        st_nxt.sda_oe = 1'b0;
                        st_nxt.st     = ST_RACK;
                    end else begin
                        st_nxt.shreg  = {st_r.shreg[6:0], 1'b0};
                        st_nxt.sda_oe = ~st_r.shreg[6];
                    end
                end
                ST_RACK: begin
                    if (st_r.nack) begin
                        st_nxt.st     = ST_IDLE;
                    end else begin
                        // Pointer advances only once the byte is acked
                        st_nxt.ptr    = rd_ptr; // [R31]
                        st_nxt.shreg  = rd_byte;
                        st_nxt.sda_oe = ~rd_byte[7];
                        st_nxt.bitcnt = 4'h0;
                        st_nxt.st     = ST_READ;
                        st_nxt.rw     = 1'b1;
                    end
                end
                ST_IDLE: begin
                end
            endcase
        end
        // Decodes from next-cycle values, so control pins come from flops
        // without adding a cycle of latency
        nr0  = st_nxt.regs[RECTIFIER_CONFIG_OFS[2:0]];
        nr1  = st_nxt.regs[CHARGE_CONFIG_OFS[2:0]];
        nr5  = st_nxt.regs[THERMISTOR_MISC_OFS[2:0]];
        nflg = st_nxt.flag_s[1];
        // Open-drain mode only ever pulls the pin low
        st_nxt.det_pin    = nr0[DETECT_CFG_BIT] & nflg[5]; // [R2]
        st_nxt.det_oe     = nr0[DETECT_CFG_BIT] | ~nflg[5]; // [R2]
        st_nxt.rect_control_a = ~nr0[CONTROL_A_BIT]; // [R4]
        st_nxt.rect_half  = nr0[CONTROL_A_BIT] & ~nr0[HALF_SYNC_BIT]; // [R3] [R4]
        st_nxt.rect_full  = nr0[CONTROL_A_BIT] & nr0[HALF_SYNC_BIT]; // [R3]
        st_nxt.ref_en     = nr0[REF_ENABLE_BIT] & ~nr5[REF_KILL_BIT]; // [R5] [R6]
        st_nxt.sw_on      = ~nr0[REGULATE_BIT] & nr0[SWITCH_ENABLE_BIT]; // [R7]
        st_nxt.ovfet_on   = nr1[OV_FORCE_BIT] | nflg[3]; // [R11]
        st_nxt.mux_en     =
            st_nxt.regs[ANALOG_SELECT_OFS[2:0]][ASEL_LSB +: 3] != ASEL_NONE; // [R16]
        // Code 3 is undefined; treated as driver off
        unique case (nr5[THERMISTOR_PIN_LSB +: 2]) // [R18]
            THERMISTOR_PIN_ON:   st_nxt.thermistor_pin_on = 1'b1; // [R19]
            THERMISTOR_PIN_AUTO: st_nxt.thermistor_pin_on = nr0[SWITCH_ENABLE_BIT]
                                          | nr0[PRECHARGE_EN_BIT]; // [R19]
            default:    st_nxt.thermistor_pin_on = 1'b0; // [R19]
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r        <= '0;
            st_r.scl_s  <= 2'h3;
            st_r.sda_s  <= 2'h3;
            st_r.scl_d  <= 1'b1;
            st_r.sda_d  <= 1'b1;
            st_r.st     <= ST_IDLE;
            st_r.regs   <= {8{CTRL_RESET}};
            st_r.det_oe     <= 1'b1;
            st_r.rect_control_a <= 1'b1;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign sda_o    = 1'b0;
    assign sda_oe_o = st_r.sda_oe;

    assign r0 = st_r.regs[RECTIFIER_CONFIG_OFS[2:0]];
    assign r1 = st_r.regs[CHARGE_CONFIG_OFS[2:0]];
    assign r5 = st_r.regs[THERMISTOR_MISC_OFS[2:0]];

    assign power_detect_o    = st_r.det_pin; // [R2]
    assign power_detect_oe_o = st_r.det_oe; // [R2]

    assign low_side_force_o   = r0[LOW_SIDE_FORCE_BIT]; // [R1]
    assign rect_control_a_o       = st_r.rect_control_a; // [R4]
    assign rect_half_sync_o   = st_r.rect_half; // [R3] [R4]
    assign rect_full_sync_o   = st_r.rect_full; // [R3]
    assign reference_enable_o = st_r.ref_en; // [R5] [R6]
    assign ls_regulator_o     = r0[REGULATE_BIT]; // [R7]
    assign ls_switch_o        = st_r.sw_on; // [R7]
    assign precharge_enable_o = r0[PRECHARGE_EN_BIT]; // [R8]
    assign precharge_level_o  = st_r.regs[PRECHARGE_LEVEL_OFS[2:0]][2:0]; // [R14]

    assign indirect_charge_select_o = r1[INDIRECT_SEL_BIT]; // [R9]
    assign pack_load_enable_o       = r1[PACK_LOAD_BIT]; // [R10]
    assign overvoltage_fet_on_o     = st_r.ovfet_on; // [R11]
    assign overvoltage_fet_mode_o   = r5[OV_FET_MODE_BIT]; // [R12]
    assign modulation_enable_o      = r1[MOD_ENABLE_BIT]; // [R13]

    assign analog_select_field_o =
        st_r.regs[ANALOG_SELECT_OFS[2:0]][ASEL_LSB +: 3]; // [R15]
    assign analog_mux_enable_o   = st_r.mux_en; // [R16]
    assign rectified_divider_ratio_o =
        st_r.regs[ANALOG_SELECT_OFS[2:0]][DIV_RATIO_BIT]; // [R15]

    assign indirect_current_limit_o =
        st_r.regs[CURRENT_LIMIT_SET_OFS[2:0]][3:0]; // [R17]

    assign thermistor_drive_o = st_r.thermistor_pin_on; // [R19]

    assign mux_pulldown_enable_o    = r5[PULLDOWN_BIT]; // [R20]
    assign core_regulator_tuning_o  = r5[CORE_TUNE_BIT]; // [R21]
    assign high_resistance_select_o = r5[HIGH_RES_BIT]; // [R22]
    assign battery_sense_gain_o =
        st_r.regs[SENSE_GAIN_OFS[2:0]][BATT_GAIN_LSB +: 3]; // [R23]
    assign output_sense_gain_o  =
        st_r.regs[SENSE_GAIN_OFS[2:0]][OUT_GAIN_LSB +: 3]; // [R23]
    // Regulator decodes the code; bit 7 of the spare register is storage only
    assign output_voltage_setpoint_o =
        st_r.regs[SPARE_CONTROL_OFS[2:0]][6:0]; // [R24] [R25]

endmodule

// *** verification/rx_ctrl_regs_sva.sv ***
`timescale 1ns/10ps
module rx_ctrl_regs_sva (
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       scl_i,
    input  wire logic       power_present_i,
    input  wire logic       rect_ov_i,
    input  wire logic       sda_o,
    input  wire logic       sda_oe_o,
    input  wire logic       power_detect_o,
    input  wire logic       power_detect_oe_o,
    input  wire logic       rect_control_a_o,
    input  wire logic       rect_half_sync_o,
    input  wire logic       rect_full_sync_o,
    input  wire logic       ls_regulator_o,
    input  wire logic       ls_switch_o,
    input  wire logic       overvoltage_fet_on_o,
    input  wire logic [2:0] analog_select_field_o,
    input  wire logic       analog_mux_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_sync_onehot: assert property (
        $onehot({rect_control_a_o, rect_half_sync_o, rect_full_sync_o}))
        else $error("rectifier mode not exactly one");
    a_ls_exclusive: assert property (!(ls_regulator_o && ls_switch_o))
        else $error("load switch both regulator and switch");
    a_mux_enable: assert property (
        analog_mux_enable_o == (analog_select_field_o != 3'h0))
        else $error("mux enable disagrees with select code");
    a_detect_drive: assert property (power_detect_o |-> power_detect_oe_o)
        else $error("detect pin high while not driven");
    // Two sync stages plus margin before the pin must follow
    a_detect_follow: assert property (
        power_present_i [*4] |-> (power_detect_o || !power_detect_oe_o))
        else $error("detect pin not showing power");
    a_ovfet_follow: assert property (rect_ov_i [*4] |-> overvoltage_fet_on_o)
        else $error("over-voltage fet off during over-voltage");
    a_sda_open_drain: assert property (sda_oe_o |-> !sda_o)
        else $error("data line driven high");
    // A change while clock is high would read as start or stop
    a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
endmodule

bind rx_ctrl_regs rx_ctrl_regs_sva u_sva (
    .clk_i, .rst_b_i, .scl_i, .power_present_i, .rect_ov_i, .sda_o, .sda_oe_o,
    .power_detect_o, .power_detect_oe_o, .rect_control_a_o, .rect_half_sync_o,
    .rect_full_sync_o, .ls_regulator_o, .ls_switch_o, .overvoltage_fet_on_o,
    .analog_select_field_o, .analog_mux_enable_o
);

// *** verification/i2c_host_model.sv ***
`timescale 1ns/10ps
module i2c_host_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    initial begin
        scl_o = 1'h1;
        sda_low_o = 1'h0;
    end
    // Two system clocks a quarter, so each clock phase lasts four
    task automatic qtr;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic start;
        sda_low_o = 1'h0;
        qtr;
        scl_o = 1'h1;
        qtr;
        sda_low_o = 1'h1;
        qtr;
        scl_o = 1'h0;
        qtr;
    endtask
    task automatic stop;
        sda_low_o = 1'h1;
        qtr;
        scl_o = 1'h1;
        qtr;
        sda_low_o = 1'h0;
        qtr;
        qtr;
    endtask
    task automatic bitx(input logic b, output logic s);
        sda_low_o = ~b;
        qtr;
        scl_o = 1'h1;
        qtr;
        s = sda_i;
        qtr;
        scl_o = 1'h0;
        qtr;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(b[i], s);
        bitx(1'h1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'h1, b[i]);
        bitx(last, s);
    endtask
    task automatic write_regs(input logic [6:0] a, input logic [7:0] ofs,
                              input logic [7:0] d[$], output logic ok);
        start;
        wbyte({a, 1'h0}, ok);
        if (ok) wbyte(ofs, ok);
        for (int i = 0; i < d.size() && ok; i++) wbyte(d[i], ok);
        stop;
    endtask
    task automatic read_regs(input logic [6:0] a, input logic [7:0] ofs, input int n,
                             output logic [7:0] d[$], output logic ok);
        logic       ack;
        logic [7:0] b;
        d = {};
        start;
        wbyte({a, 1'h0}, ok);
        wbyte(ofs, ack);
        ok = ok & ack;
        start;
        wbyte({a, 1'h1}, ack);
        ok = ok & ack;
        for (int i = 0; i < n; i++) begin
            rbyte(i == n - 1, b);
            d.push_back(b);
        end
        stop;
    endtask
endmodule

// *** verification/test_wireless_rx_control_regs.sv ***
`timescale 1ns/10ps
module test_wireless_rx_control_regs
    import rx_ctrl_pkg::*;
;
    localparam logic [43:0] M_HI = 44'hFFF80000000;
    localparam logic [43:0] M_M1 = 44'h0007FC00000;
    localparam logic [43:0] M_M2 = 44'h000003FE000;
    localparam logic [43:0] M_LO = 44'h00000001FFF;
    logic             clk_i, rst_b_i, ce_i, pw, ok, scl, sda_low, sda_o, sda_oe;
    logic [4:0]       st;
    wire logic [43:0] act;
    logic [43:0]      e;
    logic [7:0][7:0]  rm;
    logic [7:0]       d[$], q[$];
    logic [31:0]      seed;
    int               errors, num_checks, cycles;
    wire logic        sda_line = ~sda_low & (~sda_oe | sda_o);

    rx_ctrl_regs dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .power_present_i(pw), .pack_ov_i(st[4]),
        .rect_ov_i(st[3]), .over_temp_i(st[2]), .usb_present_i(st[1]),
        .current_limit_i(st[0]), .power_detect_o(act[43]), .power_detect_oe_o(act[42]),
        .low_side_force_o(act[41]), .rect_control_a_o(act[40]), .rect_half_sync_o(act[39]),
        .rect_full_sync_o(act[38]), .reference_enable_o(act[37]), .ls_regulator_o(act[36]),
        .ls_switch_o(act[35]), .precharge_enable_o(act[34]), .precharge_level_o(act[33:31]),
        .indirect_charge_select_o(act[30]), .pack_load_enable_o(act[29]),
        .overvoltage_fet_on_o(act[28]), .overvoltage_fet_mode_o(act[27]),
        .modulation_enable_o(act[26]), .analog_select_field_o(act[25:23]),
        .analog_mux_enable_o(act[22]), .rectified_divider_ratio_o(act[21]),
        .indirect_current_limit_o(act[20:17]), .thermistor_drive_o(act[16]),
        .mux_pulldown_enable_o(act[15]), .core_regulator_tuning_o(act[14]),
        .high_resistance_select_o(act[13]), .battery_sense_gain_o(act[12:10]),
        .output_sense_gain_o(act[9:7]), .output_voltage_setpoint_o(act[6:0]));
    i2c_host_model host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));

    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            stop_test;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [43:0] exp_out(input logic [7:0][7:0] r, input logic ov, p);
        logic [1:0] t;
        logic       th;
        t = r[5][1:0];
        th = (t == 2'h1) | ((t == 2'h2) & (r[0][0] | r[0][1]));
        return {r[0][6] & p, r[0][6] | ~p, r[0][7], ~r[0][4], r[0][4] & ~r[0][5],
                r[0][4] & r[0][5], r[0][3] & ~r[5][2], r[0][2], ~r[0][2] & r[0][0], r[0][1],
                r[2][2:0], r[1][3:2], r[1][1] | ov, r[5][3], r[1][0], r[3][2:0], |r[3][2:0],
                r[3][3], r[4][3:0], th, r[5][4], r[5][5], r[5][7], r[6][5:3], r[6][2:0],
                r[7][6:0]};
    endfunction
    task automatic check_bit(input string n, input logic x, a);
        num_checks++;
        if (a !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, x, a);
        end
    endtask
    task automatic check_byte(input string n, input logic [7:0] x, a);
        num_checks++;
        if (a !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, x, a);
        end
    endtask
    task automatic check_vec(input string n, input logic [43:0] x, a);
        num_checks++;
        if (a !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, x, a);
        end
    endtask
    task automatic check_outputs;
        e = exp_out(rm, st[3], pw);
        check_vec("rectifier outputs", e & M_HI, act & M_HI);
        check_vec("charge outputs", e & M_M1, act & M_M1);
        check_vec("misc outputs", e & M_M2, act & M_M2);
        check_vec("gain outputs", e & M_LO, act & M_LO);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        clk_i = 1'h0;
        rst_b_i = 1'h0;
        ce_i = 1'h1;
        pw = 1'h0;
        st = 5'h00;
        rm = 64'h0;
        seed = 32'h79D00AC2;
        repeat (20) @(posedge clk_i);
        #1 rst_b_i = 1'h1;
        repeat (3) @(posedge clk_i);
        #1;
        check_outputs;
        host.read_regs(DEV_ADDR, RECTIFIER_CONFIG_OFS, 9, q, ok);
        for (int i = 0; i < 9; i++) check_byte("reset value", CTRL_RESET, q[i]);
        for (int it = 0; it < 14; it++) begin
            for (int i = 0; i < 8; i++) begin
                seed = xs(seed);
                rm[i] = seed[7:0];
            end
            if (it == 0) rm = 64'hFFFFFFFFFFFFFFFF;
            if (it < 8) rm[3][2:0] = it[2:0];
            if (it < 4) rm[5][1:0] = it[1:0];
            seed = xs(seed);
            st = seed[4:0];
            pw = seed[5];
            d = {};
            for (int i = 0; i < 8; i++) d.push_back(rm[i]);
            host.write_regs(DEV_ADDR, RECTIFIER_CONFIG_OFS, d, ok);
            check_bit("write ack", 1'h1, ok);
            repeat (4) @(posedge clk_i);
            #1;
            check_outputs;
            host.read_regs(DEV_ADDR, RECTIFIER_CONFIG_OFS, 9, q, ok);
            for (int i = 0; i < 8; i++) check_byte("readback", rm[i], q[i]);
            check_byte("fault", {3'h0, st}, q[8]);
        end
        d = {8'h5A};
        host.write_regs(DEV_ADDR ^ 7'h01, RECTIFIER_CONFIG_OFS, d, ok);
        check_bit("foreign address ack", 1'h0, ok);
        host.write_regs(DEV_ADDR, FAULT_STATUS_OFS, d, ok);
        host.read_regs(DEV_ADDR, RECTIFIER_CONFIG_OFS, 9, q, ok);
        check_byte("reg kept", rm[0], q[0]);
        check_byte("fault read only", {3'h0, st}, q[8]);
        host.read_regs(DEV_ADDR, 8'h09, 1, q, ok);
        check_byte("unmapped read", 8'h00, q[0]);
        stop_test;
    end
endmodule
